// File: hw/chgreg_bank.sv
// Configuration register bank of a single-cell charger behind a serial register port.
//
// Contract
// - Control bits 7:6 pick input limit 100, 500, 800 mA or none.
// - Control bits 5:4 set weak-battery threshold 3.4 V plus 100 mV steps.
// - Control bit 3 set enables current-based charge termination; resets zero.
// - Control bit 2 set disables the charger; resets zero, charger enabled.
// - Control bit 1 set selects high-impedance power path; resets zero.
// - Control bit 0 selects boost when set; inert on non-boost variants.
// - Battery bits 7:2 code regulation 3.5 V plus 20 mV steps, default 3.54 V.
// - Battery bit 1 sets OTG pin active level; one is high; resets one.
// - Battery bit 0 enables the OTG pin; resets zero; boost variants only.
// - Identification is read-only: vendor 7:5, address-based part 4:3, revision 2:0.
// - Writing one to current bit 7 resets the charger; reads zero.
// - Current bits 6:3 set charge sense; bit 3 unused on three-bit variants.
// - Current bits 2:0 set termination sense; bits 2 and 1 reset zero.
// - Reset loads 30h control, 0Ah battery voltage, 01h current register.
// - A write takes effect at the acknowledge falling edge after data.
// - Reading any unimplemented location returns FFh.
`timescale 1ns/1ps

module chgreg_bank
    import chgreg_pkg::*;
#(
    parameter bit         BOOST_CAPABLE = 1'b1,
    parameter bit         FOUR_BIT_CHG  = 1'b0,
    parameter logic [1:0] LIMIT_RST     = 2'h0,
    parameter logic [2:0] VENDOR_CODE   = CHGREG_VENDOR_DEF,
    parameter logic [1:0] PART_CODE_A   = CHGREG_PART_A_DEF,
    parameter logic [1:0] PART_CODE_B   = CHGREG_PART_B_DEF,
    parameter logic [2:0] REVISION_CODE = CHGREG_REV_DEF
) (
    input  wire logic       clk_sys,
    input  wire logic       arst_n,
    input  wire logic       ack_fall,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic       rd_req,
    input  wire logic       addr_select,
    input  wire logic       otg_pin,
    output logic      [7:0] rd_data_q,
    output logic            rd_valid_q,
    output logic      [1:0] input_current_limit,
    output logic      [1:0] weak_battery_threshold,
    output logic            termination_enable,
    output logic            charger_disable,
    output logic            high_impedance_select,
    output logic            boost_select,
    output logic      [5:0] regulation_voltage_code,
    output logic            otg_pin_polarity,
    output logic            otg_pin_enable,
    output logic      [3:0] charge_sense_code,
    output logic      [2:0] termination_sense_code,
    output logic            otg_request_q,
    output logic            charger_reset_q
);

    // ====================================================================
    // Reset synchroniser
    logic       rst_meta_q;
    logic       rst_n_q;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ====================================================================
    // Write decode
    logic [1:0] part_q;
    logic       wr_ctrl;
    logic       wr_batv;
    logic       wr_curr;

    // One compare serves every strobe, so a new offset cannot split them apart.
    function automatic logic chgreg_hit(input logic [7:0] addr, input logic [7:0] ofs);
        chgreg_hit = (addr == ofs);
    endfunction : chgreg_hit

    assign wr_ctrl = ack_fall && chgreg_hit(reg_addr, CHGREG_CTRL_OFS);
    assign wr_batv = ack_fall && chgreg_hit(reg_addr, CHGREG_BATV_OFS);
    assign wr_curr = ack_fall && chgreg_hit(reg_addr, CHGREG_CURR_OFS);

    // ====================================================================
    // Charger control fields
    logic [1:0] limit_q;
    logic [1:0] weak_q;
    logic       term_en_q;
    logic       chg_dis_q;
    logic       hiz_q;
    logic       boost_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            limit_q <= LIMIT_RST;
        end else if (wr_ctrl) begin
            limit_q <= wr_data[CHGREG_LIMIT_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            weak_q <= CHGREG_CTRL_RST[CHGREG_WEAK_LSB +: 2];
        end else if (wr_ctrl) begin
            weak_q <= wr_data[CHGREG_WEAK_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            term_en_q <= CHGREG_CTRL_RST[CHGREG_TERM_EN_BIT];
        end else if (wr_ctrl) begin
            term_en_q <= wr_data[CHGREG_TERM_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chg_dis_q <= CHGREG_CTRL_RST[CHGREG_CHG_DIS_BIT];
        end else if (wr_ctrl) begin
            chg_dis_q <= wr_data[CHGREG_CHG_DIS_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hiz_q <= CHGREG_CTRL_RST[CHGREG_HIZ_BIT];
        end else if (wr_ctrl) begin
            hiz_q <= wr_data[CHGREG_HIZ_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            boost_q <= CHGREG_CTRL_RST[CHGREG_BOOST_BIT];
        end else if (wr_ctrl) begin
            boost_q <= wr_data[CHGREG_BOOST_BIT];
        end
    end

    // ====================================================================
    // Battery voltage fields
    logic [5:0] vreg_q;
    logic       otg_pol_q;
    logic       otg_pin_enable_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            vreg_q <= CHGREG_BATV_RST[CHGREG_VREG_LSB +: 6];
        end else if (wr_batv) begin
            vreg_q <= wr_data[CHGREG_VREG_LSB +: 6];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            otg_pol_q <= CHGREG_BATV_RST[CHGREG_OTG_POL_BIT];
        end else if (wr_batv) begin
            otg_pol_q <= wr_data[CHGREG_OTG_POL_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            otg_pin_enable_q <= CHGREG_BATV_RST[CHGREG_OTG_PIN_ENABLE_BIT];
        end else if (wr_batv) begin
            otg_pin_enable_q <= wr_data[CHGREG_OTG_PIN_ENABLE_BIT];
        end
    end

    // ====================================================================
    // Current sense fields
    logic [3:0] chg_sns_q;
    logic [2:0] term_sns_q;

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chg_sns_q <= CHGREG_CURR_RST[CHGREG_CHG_SNS_LSB +: 4];
        end else if (wr_curr) begin
            chg_sns_q <= wr_data[CHGREG_CHG_SNS_LSB +: 4];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            term_sns_q <= CHGREG_CURR_RST[2:0];
        end else if (wr_curr) begin
            term_sns_q <= wr_data[2:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            charger_reset_q <= 1'b0;
        end else begin
            charger_reset_q <= wr_curr && wr_data[CHGREG_RESET_BIT];
        end
    end

    function automatic logic [1:0] chgreg_part(input logic strap);
        chgreg_part = strap ? PART_CODE_A : PART_CODE_B;
    endfunction : chgreg_part

    // The part code follows the bus address strap, sampled on every clock after reset release.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            part_q <= 2'h0;
        end else begin
            part_q <= chgreg_part(addr_select);
        end
    end

    // ====================================================================
    // Control outputs
    assign input_current_limit     = limit_q;
    assign weak_battery_threshold  = weak_q;
    assign termination_enable      = term_en_q;
    assign charger_disable         = chg_dis_q;
    assign high_impedance_select   = hiz_q;
    assign boost_select            = BOOST_CAPABLE && boost_q;
    assign regulation_voltage_code = vreg_q;
    assign otg_pin_polarity        = otg_pol_q;
    assign otg_pin_enable          = BOOST_CAPABLE && otg_pin_enable_q;
    // unused bit masked on three-bit variants
    assign charge_sense_code       = {chg_sns_q[3:1], FOUR_BIT_CHG && chg_sns_q[0]};
    assign termination_sense_code  = term_sns_q;

    // An ignored OTG pin must never request boost, so the enable gates the match.
    // OTG pin qualification
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            otg_request_q <= 1'b0;
        end else begin
            otg_request_q <= otg_pin_enable && (otg_pin == otg_pin_polarity);
        end
    end

    // ====================================================================
    // Register images as the host reads them
    logic [7:0] ctrl_img;
    logic [7:0] batv_img;
    logic [7:0] curr_img;

    assign ctrl_img = {limit_q, weak_q, term_en_q, chg_dis_q, hiz_q, boost_q};
    assign batv_img = {vreg_q, otg_pol_q, otg_pin_enable_q};
    assign curr_img = {1'b0, chg_sns_q, term_sns_q};

    // ====================================================================
    // Read path
    logic [7:0] rd_mux;

    function automatic logic [7:0] chgreg_ident(input logic [1:0] part);
        chgreg_ident = {VENDOR_CODE, part, REVISION_CODE};
    endfunction : chgreg_ident

    always_comb begin
        unique case (reg_addr)
            CHGREG_CTRL_OFS:  rd_mux = ctrl_img;
            CHGREG_BATV_OFS:  rd_mux = batv_img;
            CHGREG_IDENT_OFS: rd_mux = chgreg_ident(part_q);
            CHGREG_CURR_OFS:  rd_mux = curr_img;
            default:          rd_mux = CHGREG_UNMAPPED;
        endcase
    end

    // identification has no write path, so its writes simply vanish.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_data_q <= CHGREG_UNMAPPED;
        end else if (rd_req) begin
            rd_data_q <= rd_mux;
        end
    end

    // The strobe marks the one cycle in which fresh read data first stands.
    always_ff @(posedge clk_sys or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_req;
        end
    end

endmodule : chgreg_bank

// File: hw/chgreg_pkg.sv
// Package with offsets, field positions and reset values of the charger register bank.
package chgreg_pkg;

    // ====================================================================
    // Register offsets
    localparam logic [7:0] CHGREG_CTRL_OFS  = 8'h01;
    localparam logic [7:0] CHGREG_BATV_OFS  = 8'h02;
    localparam logic [7:0] CHGREG_IDENT_OFS = 8'h03;
    localparam logic [7:0] CHGREG_CURR_OFS  = 8'h04;

    // ====================================================================
    // Reset values
    localparam logic [7:0] CHGREG_CTRL_RST  = 8'h30;
    localparam logic [7:0] CHGREG_BATV_RST  = 8'h0a;
    localparam logic [7:0] CHGREG_CURR_RST  = 8'h01;
    localparam logic [7:0] CHGREG_UNMAPPED  = 8'hff;

    // ====================================================================
    // Field positions
    localparam int CHGREG_LIMIT_LSB    = 6;
    localparam int CHGREG_WEAK_LSB     = 4;
    localparam int CHGREG_TERM_EN_BIT  = 3;
    localparam int CHGREG_CHG_DIS_BIT  = 2;
    localparam int CHGREG_HIZ_BIT      = 1;
    localparam int CHGREG_BOOST_BIT    = 0;
    localparam int CHGREG_VREG_LSB     = 2;
    localparam int CHGREG_OTG_POL_BIT  = 1;
    localparam int CHGREG_OTG_PIN_ENABLE_BIT   = 0;
    localparam int CHGREG_RESET_BIT    = 7;
    localparam int CHGREG_CHG_SNS_LSB  = 3;
    localparam int CHGREG_VENDOR_LSB   = 5;
    localparam int CHGREG_PART_LSB     = 3;

    // ====================================================================
    // Identification defaults; the values are arbitrary.
    localparam logic [2:0] CHGREG_VENDOR_DEF = 3'h5;
    localparam logic [1:0] CHGREG_PART_A_DEF = 2'h2;
    localparam logic [1:0] CHGREG_PART_B_DEF = 2'h1;
    localparam logic [2:0] CHGREG_REV_DEF    = 3'h6;

endpackage : chgreg_pkg

// File: tb/chgreg_bank_bench.sv
// Self-checking bench of the charger register bank driven by a host model.
`timescale 1ns/1ps
module chgreg_bank_bench
    import chgreg_pkg::*;
;
    logic       clk_sys = 1'b0;
    logic       arst_n = 1'b0;
    logic       addr_select = 1'b1;
    logic       otg_pin = 1'b1;
    logic       ack_fall, rd_req, boost_select, otg_request_q, charger_reset_q;
    logic [7:0] reg_addr, wr_data, rd_data_q, rd;
    logic [1:0] input_current_limit;
    logic [5:0] regulation_voltage_code;
    logic [3:0] charge_sense_code;
    int         error_cnt = 0;
    int         checks_done = 0;
    int         cycles = 0;
    always #10 clk_sys = ~clk_sys;
    chgreg_host chgreg_host_inst (.clk_sys, .rd_data_q, .ack_fall, .reg_addr, .wr_data, .rd_req);
    chgreg_bank chgreg_bank_inst (.clk_sys, .arst_n, .ack_fall, .reg_addr, .wr_data, .rd_req,
        .addr_select, .otg_pin, .rd_data_q, .rd_valid_q(), .input_current_limit,
        .weak_battery_threshold(), .termination_enable(), .charger_disable(),
        .high_impedance_select(), .boost_select, .regulation_voltage_code,
        .otg_pin_polarity(), .otg_pin_enable(), .charge_sense_code,
        .termination_sense_code(), .otg_request_q, .charger_reset_q);
    // ====================================================================
    // Scenarios
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        chgreg_host_inst.rd(a, rd);
        cmp($sformatf("addr %h", a), e, rd);
    endtask : rchk
    task automatic report_and_stop;
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic t_regs;
        logic [7:0] v[4] = '{8'h00, 8'h5a, 8'ha5, 8'hff};
        rchk(CHGREG_CTRL_OFS, CHGREG_CTRL_RST);
        rchk(CHGREG_BATV_OFS, CHGREG_BATV_RST);
        rchk(CHGREG_CURR_OFS, CHGREG_CURR_RST);
        foreach (v[i]) begin
            chgreg_host_inst.wr(CHGREG_CTRL_OFS, v[i]);
            rchk(CHGREG_CTRL_OFS, v[i]);
            cmp("limit", {6'h0, v[i][7:6]}, {6'h0, input_current_limit});
            cmp("boost", {7'h0, v[i][0]}, {7'h0, boost_select});
        end
        chgreg_host_inst.wr(CHGREG_BATV_OFS, 8'hfd);
        otg_pin <= 1'b0;
        rchk(CHGREG_BATV_OFS, 8'hfd);
        cmp("vreg", 8'h3f, {2'h0, regulation_voltage_code});
        cmp("otg", 8'h01, {7'h0, otg_request_q});
        chgreg_host_inst.wr(CHGREG_CURR_OFS, 8'hff);
        @(negedge clk_sys);
        cmp("chg reset", 8'h01, {7'h0, charger_reset_q});
        rchk(CHGREG_CURR_OFS, 8'h7f);
        cmp("chg sense", 8'h0e, {4'h0, charge_sense_code});
    endtask : t_regs
    task automatic t_ident;
        chgreg_host_inst.wr(CHGREG_IDENT_OFS, 8'h00);
        rchk(CHGREG_IDENT_OFS, {CHGREG_VENDOR_DEF, CHGREG_PART_A_DEF, CHGREG_REV_DEF});
        @(posedge clk_sys);
        addr_select <= 1'b0;
        rchk(CHGREG_IDENT_OFS, {CHGREG_VENDOR_DEF, CHGREG_PART_B_DEF, CHGREG_REV_DEF});
        rchk(8'h00, 8'hff);
        rchk(8'h05, 8'hff);
        rchk(8'hff, 8'hff);
    endtask : t_ident
    initial begin
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_regs();
        t_ident();
        report_and_stop();
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            error_cnt++;
            report_and_stop();
        end
    end
endmodule : chgreg_bank_bench

// File: tb/chgreg_bank_monitor.sv
// Checker on the ports of the charger register bank.
`timescale 1ns/1ps
module chgreg_bank_monitor
    import chgreg_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       arst_n,
    input wire logic       ack_fall,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] wr_data,
    input wire logic       rd_req,
    input wire logic       addr_select,
    input wire logic [7:0] rd_data_q,
    input wire logic       rd_valid_q,
    input wire logic [1:0] input_current_limit,
    input wire logic [1:0] weak_battery_threshold,
    input wire logic       termination_enable,
    input wire logic       high_impedance_select,
    input wire logic       charger_disable,
    input wire logic       boost_select,
    input wire logic [5:0] regulation_voltage_code,
    input wire logic       otg_pin_polarity,
    input wire logic       otg_pin_enable,
    input wire logic [3:0] charge_sense_code,
    input wire logic [2:0] termination_sense_code,
    input wire logic       charger_reset_q
);
    // ====================================================================
    // Properties
    logic [7:0] wd_q;
    wire logic  wc = ack_fall && reg_addr == CHGREG_CTRL_OFS;
    wire logic  wb = ack_fall && reg_addr == CHGREG_BATV_OFS;
    wire logic  wi = ack_fall && reg_addr == CHGREG_CURR_OFS;
    always_ff @(posedge clk_sys) wd_q <= wr_data;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_limit_write: assert property (wc |=> input_current_limit == wd_q[7:6])
        else $error("limit field not written");
    chk_disable_write: assert property (wc |=> charger_disable == wd_q[2])
        else $error("charger disable not written");
    chk_boost_write: assert property (wc |=> boost_select == wd_q[0])
        else $error("boost select not written");
    chk_vreg_write: assert property (wb |=> regulation_voltage_code == wd_q[7:2])
        else $error("regulation code not written");
    chk_sense_write: assert property (wi |=> charge_sense_code == {wd_q[6:4], 1'b0}
        && termination_sense_code == wd_q[2:0]) else $error("sense codes not written");
    chk_ctrl_fields: assert property (wc |=> weak_battery_threshold == wd_q[5:4]
        && termination_enable == wd_q[3] && high_impedance_select == wd_q[1])
        else $error("control fields not written");
    chk_otg_fields: assert property (wb |=> otg_pin_polarity == wd_q[1]
        && otg_pin_enable == wd_q[0]) else $error("otg fields not written");
    chk_reset_pulse: assert property (wi && wr_data[7] |=> charger_reset_q)
        else $error("charger reset pulse missing");
    chk_reset_pulse_end: assert property (!(wi && wr_data[7]) |=> !charger_reset_q)
        else $error("charger reset pulse without request");
    chk_vreg_hold: assert property (!ack_fall |=> $stable(regulation_voltage_code))
        else $error("regulation code changed without write");
    chk_unmapped_read: assert property (rd_req && (reg_addr == 8'h00 || reg_addr > 8'h04)
        |=> rd_valid_q && rd_data_q == 8'hff) else $error("unmapped read not ff");
    chk_ident_read: assert property (rd_req && reg_addr == CHGREG_IDENT_OFS |=> rd_data_q ==
        {CHGREG_VENDOR_DEF, $past(addr_select, 2) ? CHGREG_PART_A_DEF : CHGREG_PART_B_DEF,
        CHGREG_REV_DEF}) else $error("identification read wrong");
    chk_reset_load: assert property ($rose(arst_n) |-> input_current_limit == CHGREG_CTRL_RST[7:6]
        && regulation_voltage_code == CHGREG_BATV_RST[7:2]
        && termination_sense_code == CHGREG_CURR_RST[2:0])
        else $error("reset values wrong");
    cover property (wc);
    cover property (wi && wr_data[7]);
    cover property (rd_req && reg_addr == CHGREG_IDENT_OFS);
    cover property (rd_req && reg_addr > CHGREG_CURR_OFS);
endmodule : chgreg_bank_monitor

bind chgreg_bank chgreg_bank_monitor chgreg_bank_monitor_inst (.*);

// File: tb/chgreg_host.sv
// Host model issuing register writes and reads at the bank's port.
`timescale 1ns/1ps
module chgreg_host (
    input  wire logic       clk_sys,
    input  wire logic [7:0] rd_data_q,
    output logic            ack_fall = 1'b0,
    output logic      [7:0] reg_addr = 8'h00,
    output logic      [7:0] wr_data  = 8'h00,
    output logic            rd_req   = 1'b0
);
    // ====================================================================
    // Transfers; released lines carry the inverse so stale data never looks valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        ack_fall <= 1'b1;
        reg_addr <= a;
        wr_data  <= d;
        @(posedge clk_sys);
        ack_fall <= 1'b0;
        reg_addr <= ~a;
        wr_data  <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        rd_req   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        rd_req   <= 1'b0;
        reg_addr <= ~a;
        @(negedge clk_sys);
        d = rd_data_q;
    endtask : rd
endmodule : chgreg_host
